// File: rtl/fcs_pkg.sv
// constants and carrier types for the floating controller support logic
package fcs_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 25_000_000;
  // serial link to the i/o processor
  localparam int unsigned LINK_BIT_RATE = 187_500;
  localparam int unsigned LINK_BIT_CYC = CLK_HZ / LINK_BIT_RATE;
  localparam int unsigned LINK_HALF_CYC = LINK_BIT_CYC / 2;
  localparam int unsigned LINK_DATA_BITS = 9;
  localparam int unsigned LINK_FRAME_BITS = 11;
  localparam int unsigned LINK_BAUD_W = 8;
  localparam int unsigned LINK_BITCNT_W = 4;
  // line frequency window, in hertz
  localparam int unsigned LINE_LO_HZ = 55;
  localparam int unsigned LINE_HI_HZ = 66;
  localparam int unsigned LINE_STD60_HZ = 60;
  localparam int unsigned LINE_STD50_HZ = 50;
  // period bounds in clock cycles: longest rounds down, least rounds up
  localparam int unsigned LINE_PER_MAX = CLK_HZ / LINE_LO_HZ;
  localparam int unsigned LINE_PER_MIN =
    (CLK_HZ + LINE_HI_HZ - 1) / LINE_HI_HZ;
  localparam int unsigned LINE_CNT_W = 20;
  // pwm repetition rate
  localparam int unsigned PWM_HZ = 23_000;
  localparam int unsigned PWM_CYC = CLK_HZ / PWM_HZ;
  localparam int unsigned PWM_W = 11;
  // measurement counter
  localparam int unsigned CNT_HI_W = 16;
  localparam int unsigned CNT_LO_W = 8;
  // fifo in the transmit path
  localparam int unsigned TX_FIFO_DEPTH = 16;
  // reset values
  localparam logic LINE_STD60_RST = 1'b0;
  localparam logic MAIN_RESET_N_RST = 1'b0;

  typedef struct packed {
    logic [CNT_HI_W-1:0] hi;
    logic [CNT_LO_W-1:0] lo;
  } fcs_count_t;

  typedef struct packed {
    logic regulated_low;
    logic unregulated_low;
    logic wr_strobe_n;
  } fcs_supply_t;

  typedef enum logic [0:0] {
    FCS_TX_IDLE = 1'b0,
    FCS_TX_SHIFT = 1'b1
  } fcs_tx_st_t;

  typedef enum logic [1:0] {
    FCS_RX_IDLE = 2'b00,
    FCS_RX_START = 2'b01,
    FCS_RX_DATA = 2'b10,
    FCS_RX_STOP = 2'b11
  } fcs_rx_st_t;
endpackage

// File: rtl/fcs_fifo.sv
// synchronous fifo with registered flags, valid and ready on both sides
`timescale 1ns/1ps
module fcs_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("fcs_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
  logic push, pop;

  assign push = in_valid && in_ready_q;
  assign pop = out_valid_q && out_ready;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem[rd_q];

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    in_ready_d = cnt_d != (AW+1)'(DEPTH);
    out_valid_d = cnt_d != '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// File: rtl/fcs_top.sv
// floating controller support logic: link, line class, counter, pwm, supply
//
// Overview of operation
// - each link character is start bit, nine data bits, one stop bit.
// - both link ends send and sample bits at 187.5 kbit per second.
// - line sense frequency from 55 to 66 Hz selects the 60 Hz standard.
// - any line frequency outside that window selects the 50 Hz standard.
// - a 16-bit counter counts carry pulses, forming 24 bits with low byte.
// - main controller reset is asserted while regulated supply is low.
// - write strobe is held inactive while the regulated supply is low.
// - power loss warning follows the unregulated supply, ahead of collapse.
// - pwm output repeats at 23 kHz, duty sets precharge adjust level.
// - converter input chosen per conversion: residual charge or freq range.
// - all logic in the block runs from one oscillator clock.
// - a count latch request captures the counter for read out.
`timescale 1ns/1ps
module fcs_top
  import fcs_pkg::*;
#(
  parameter int unsigned LINE_MIN_CYC = fcs_pkg::LINE_PER_MIN,
  parameter int unsigned LINE_MAX_CYC = fcs_pkg::LINE_PER_MAX
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link transmit side
  input wire logic tx_valid,
  input wire logic [fcs_pkg::LINK_DATA_BITS-1:0] tx_data,
  output logic tx_ready,
  output logic link_tx_line,
  // link receive side
  input wire logic link_rx_line,
  output logic rx_valid,
  output logic [fcs_pkg::LINK_DATA_BITS-1:0] rx_data,
  output logic rx_frame_err,
  // line classification
  input wire logic line_sense_input,
  output logic line_std60,
  output logic line_meas_done,
  // measurement counter
  input wire logic counter_carry_pulse,
  input wire logic [fcs_pkg::CNT_LO_W-1:0] count_low,
  input wire logic count_latch_req,
  output logic count_latch_strobe,
  output fcs_pkg::fcs_count_t count_value,
  // supply supervisor
  input wire fcs_pkg::fcs_supply_t supply_in,
  output logic main_reset_n,
  output logic power_loss_warning,
  output logic wr_strobe_n_out,
  // pwm
  input wire logic [fcs_pkg::PWM_W-1:0] pwm_duty,
  output logic precharge_adjust_level,
  // converter input selection, 1 selects frequency_range_input
  input wire logic adc_start_req,
  input wire logic adc_sel_freq,
  output logic adc_input_sel,
  output logic adc_start
);
  import fcs_pkg::*;

  if (LINE_MIN_CYC >= LINE_MAX_CYC || LINE_MAX_CYC >= (1 << LINE_CNT_W)
      || PWM_CYC >= (1 << PWM_W)) begin : g_chk
    $error("fcs_top: line window or pwm period out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit fifo and serializer

  logic fifo_valid, fifo_pop;
  logic [LINK_DATA_BITS-1:0] fifo_data;
  fcs_tx_st_t tx_st_q, tx_st_d;
  logic [LINK_FRAME_BITS-1:0] tx_sh_q, tx_sh_d;
  logic [LINK_BAUD_W-1:0] tx_baud_q, tx_baud_d;
  logic [LINK_BITCNT_W-1:0] tx_bit_q, tx_bit_d;
  logic tx_line_q, tx_line_d;

  fcs_fifo #(.WIDTH(LINK_DATA_BITS), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // serializer only drains while idle, so the fifo really fills
  assign fifo_pop = (tx_st_q == FCS_TX_IDLE);

  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_baud_d = tx_baud_q;
    tx_bit_d = tx_bit_q;
    tx_line_d = tx_line_q;
    case (tx_st_q)
      FCS_TX_IDLE: begin
        tx_line_d = 1'b1;
        if (fifo_valid) begin
          // stop, data lsb first, start
          tx_sh_d = {1'b1, fifo_data, 1'b0};
          tx_line_d = 1'b0;
          tx_baud_d = LINK_BAUD_W'(LINK_BIT_CYC - 1);
          tx_bit_d = '0;
          tx_st_d = FCS_TX_SHIFT;
        end
      end
      FCS_TX_SHIFT: begin
        if (tx_baud_q != '0) begin
          tx_baud_d = tx_baud_q - 1'b1;
        end else if (tx_bit_q == LINK_BITCNT_W'(LINK_FRAME_BITS - 1)) begin
          tx_line_d = 1'b1;
          tx_st_d = FCS_TX_IDLE;
        end else begin
          tx_sh_d = {1'b1, tx_sh_q[LINK_FRAME_BITS-1:1]};
          tx_line_d = tx_sh_q[1];
          tx_baud_d = LINK_BAUD_W'(LINK_BIT_CYC - 1);
          tx_bit_d = tx_bit_q + 1'b1;
        end
      end
      default: tx_st_d = FCS_TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= FCS_TX_IDLE;
      tx_sh_q <= '1;
      tx_baud_q <= '0;
      tx_bit_q <= '0;
      tx_line_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_baud_q <= tx_baud_d;
      tx_bit_q <= tx_bit_d;
      tx_line_q <= tx_line_d;
    end
  end
  assign link_tx_line = tx_line_q;

  ////////////////////////////////////////////////////////////////////////////
  // receiver: samples each bit at its middle

  fcs_rx_st_t rx_st_q, rx_st_d;
  logic [LINK_DATA_BITS-1:0] rx_sh_q, rx_sh_d;
  logic [LINK_BAUD_W-1:0] rx_baud_q, rx_baud_d;
  logic [LINK_BITCNT_W-1:0] rx_bit_q, rx_bit_d;
  logic rx_valid_q, rx_valid_d, rx_err_q, rx_err_d;
  logic [LINK_DATA_BITS-1:0] rx_data_q, rx_data_d;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_baud_d = rx_baud_q;
    rx_bit_d = rx_bit_q;
    rx_valid_d = 1'b0;
    rx_err_d = 1'b0;
    rx_data_d = rx_data_q;
    if (rx_st_q != FCS_RX_IDLE && rx_baud_q != '0) begin
      rx_baud_d = rx_baud_q - 1'b1;
    end else begin
      case (rx_st_q)
        FCS_RX_IDLE: begin
          if (!link_rx_line) begin
            rx_baud_d = LINK_BAUD_W'(LINK_HALF_CYC - 1);
            rx_st_d = FCS_RX_START;
          end
        end
        FCS_RX_START: begin
          // a short low glitch is not a start bit
          rx_st_d = link_rx_line ? FCS_RX_IDLE : FCS_RX_DATA;
          rx_baud_d = LINK_BAUD_W'(LINK_BIT_CYC - 1);
          rx_bit_d = '0;
        end
        FCS_RX_DATA: begin
          rx_sh_d = {link_rx_line, rx_sh_q[LINK_DATA_BITS-1:1]};
          rx_baud_d = LINK_BAUD_W'(LINK_BIT_CYC - 1);
          rx_bit_d = rx_bit_q + 1'b1;
          if (rx_bit_q == LINK_BITCNT_W'(LINK_DATA_BITS - 1)) begin
            rx_st_d = FCS_RX_STOP;
          end
        end
        FCS_RX_STOP: begin
          rx_valid_d = link_rx_line;
          rx_err_d = !link_rx_line;
          rx_data_d = rx_sh_q;
          rx_st_d = FCS_RX_IDLE;
        end
        default: rx_st_d = FCS_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= FCS_RX_IDLE;
      rx_sh_q <= '0;
      rx_baud_q <= '0;
      rx_bit_q <= '0;
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_data_q <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_baud_q <= rx_baud_d;
      rx_bit_q <= rx_bit_d;
      rx_valid_q <= rx_valid_d;
      rx_err_q <= rx_err_d;
      rx_data_q <= rx_data_d;
    end
  end
  assign rx_valid = rx_valid_q;
  assign rx_frame_err = rx_err_q;
  assign rx_data = rx_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // line frequency: cycles between rising edges of the sense input

  logic line_prev_q, line_prev_d, std60_q, std60_d, done_q, done_d;
  logic [LINE_CNT_W-1:0] per_q, per_d;
  logic line_rise, per_in_win;

  assign line_rise = line_sense_input && !line_prev_q;
  assign per_in_win = per_q >= LINE_CNT_W'(LINE_MIN_CYC)
                      && per_q <= LINE_CNT_W'(LINE_MAX_CYC);

  always_comb begin
    line_prev_d = line_sense_input;
    std60_d = std60_q;
    done_d = 1'b0;
    per_d = per_q;
    if (line_rise) begin
      std60_d = per_in_win;
      done_d = 1'b1;
      per_d = LINE_CNT_W'(1);
    end else if (per_q > LINE_CNT_W'(LINE_MAX_CYC)) begin
      // no edge for too long: line is too slow, fall back to 50 Hz
      std60_d = 1'b0;
    end else begin
      per_d = per_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_q <= 1'b0;
      std60_q <= LINE_STD60_RST;
      done_q <= 1'b0;
      per_q <= '0;
    end else begin
      line_prev_q <= line_prev_d;
      std60_q <= std60_d;
      done_q <= done_d;
      per_q <= per_d;
    end
  end
  assign line_std60 = std60_q;
  assign line_meas_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // measurement counter extension and latch

  logic carry_prev_q, carry_prev_d, strobe_q, strobe_d, carry_rise;
  logic [CNT_HI_W-1:0] hi_q, hi_d;
  fcs_count_t cval_q, cval_d;

  assign carry_rise = counter_carry_pulse && !carry_prev_q;

  always_comb begin
    carry_prev_d = counter_carry_pulse;
    hi_d = carry_rise ? hi_q + 1'b1 : hi_q;
    strobe_d = count_latch_req;
    cval_d = cval_q;
    if (count_latch_req) begin
      cval_d = '{hi: hi_q, lo: count_low};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_prev_q <= 1'b0;
      hi_q <= '0;
      strobe_q <= 1'b0;
      cval_q <= '0;
    end else begin
      carry_prev_q <= carry_prev_d;
      hi_q <= hi_d;
      strobe_q <= strobe_d;
      cval_q <= cval_d;
    end
  end
  assign count_latch_strobe = strobe_q;
  assign count_value = cval_q;

  ////////////////////////////////////////////////////////////////////////////
  // supervisor, pwm and converter input selection

  logic mrst_n_q, mrst_n_d, warn_q, warn_d, wr_n_q, wr_n_d;
  logic [PWM_W-1:0] pwm_cnt_q, pwm_cnt_d, duty_q, duty_d;
  logic pwm_q, pwm_d, asel_q, asel_d, astart_q, astart_d;

  always_comb begin
    mrst_n_d = !supply_in.regulated_low;
    warn_d = supply_in.unregulated_low;
    // writes blocked so a sagging supply cannot corrupt memory
    wr_n_d = supply_in.regulated_low ? 1'b1 : supply_in.wr_strobe_n;
    pwm_cnt_d = (pwm_cnt_q == PWM_W'(PWM_CYC - 1)) ? '0 : pwm_cnt_q + 1'b1;
    // duty taken only at period start so no runt pulses
    duty_d = (pwm_cnt_q == PWM_W'(PWM_CYC - 1)) ? pwm_duty : duty_q;
    pwm_d = pwm_cnt_d < duty_d;
    asel_d = adc_start_req ? adc_sel_freq : asel_q;
    astart_d = adc_start_req;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mrst_n_q <= MAIN_RESET_N_RST;
      warn_q <= 1'b0;
      wr_n_q <= 1'b1;
      pwm_cnt_q <= '0;
      duty_q <= '0;
      pwm_q <= 1'b0;
      asel_q <= 1'b0;
      astart_q <= 1'b0;
    end else begin
      mrst_n_q <= mrst_n_d;
      warn_q <= warn_d;
      wr_n_q <= wr_n_d;
      pwm_cnt_q <= pwm_cnt_d;
      duty_q <= duty_d;
      pwm_q <= pwm_d;
      asel_q <= asel_d;
      astart_q <= astart_d;
    end
  end
  assign main_reset_n = mrst_n_q;
  assign power_loss_warning = warn_q;
  assign wr_strobe_n_out = wr_n_q;
  assign precharge_adjust_level = pwm_q;
  assign adc_input_sel = asel_q;
  assign adc_start = astart_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks; all logic shares ref_clk

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  localparam int BIT_M1 = LINK_BIT_CYC - 1;

  sequence s_frame_start;
    tx_st_q == FCS_TX_IDLE && fifo_valid;
  endsequence
  sequence s_start_bit;
    !tx_line_q [*8];
  endsequence

  property p_start_low;
    s_frame_start |=> s_start_bit;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_bit_time;
    s_frame_start |=> ##BIT_M1 (tx_baud_q == '0 && tx_bit_q == '0)
      ##1 tx_bit_q == LINK_BITCNT_W'(1);
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("bit time wrong");

  property p_idle_high;
    tx_st_q == FCS_TX_IDLE && !fifo_valid |=> tx_line_q;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("link not idle high");

  property p_std60;
    line_rise && per_in_win |=> line_std60 && line_meas_done;
  endproperty
  a_std60: assert property (p_std60)
    else $error("60 Hz standard not chosen");

  property p_std50;
    line_rise && !per_in_win |=> !line_std60;
  endproperty
  a_std50: assert property (p_std50)
    else $error("50 Hz standard not chosen");

  property p_carry;
    carry_rise |=> hi_q == $past(hi_q) + 1'b1;
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry not counted");

  property p_latch;
    count_latch_req |=> count_latch_strobe
      && count_value.hi == $past(hi_q) && count_value.lo == $past(count_low);
  endproperty
  a_latch: assert property (p_latch)
    else $error("count not captured atomically");

  property p_reset_low;
    supply_in.regulated_low |=> !main_reset_n && wr_strobe_n_out;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("reset or write block missing");

  property p_wr_pass;
    !supply_in.regulated_low |=>
      wr_strobe_n_out == $past(supply_in.wr_strobe_n);
  endproperty
  a_wr_pass: assert property (p_wr_pass)
    else $error("write strobe not passed");

  property p_warn;
    supply_in.unregulated_low |=> power_loss_warning;
  endproperty
  a_warn: assert property (p_warn)
    else $error("power loss warning missing");

  property p_pwm_wrap;
    pwm_cnt_q == PWM_W'(PWM_CYC - 1) |=> pwm_cnt_q == '0;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap)
    else $error("pwm period wrong");

  property p_adc_sel;
    adc_start_req |=> adc_start && adc_input_sel == $past(adc_sel_freq);
  endproperty
  a_adc_sel: assert property (p_adc_sel)
    else $error("converter input not selected");
endmodule

// File: dv/fcs_iop_model.sv
// behavioural i/o processor at the far end of the serial link
`timescale 1ns/1ps
module fcs_iop_model
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial lines, named from the device side
  input wire logic dev_tx_line,
  output logic dev_rx_line,
  // bench side
  input wire logic send,
  input wire logic [fcs_pkg::LINK_DATA_BITS-1:0] send_data,
  input wire logic bad_stop,
  output logic busy,
  output logic got_valid,
  output logic [fcs_pkg::LINK_DATA_BITS-1:0] got_data,
  output logic got_err
);
  import fcs_pkg::*;
  logic [LINK_FRAME_BITS-1:0] tx_frame;
  logic [LINK_FRAME_BITS-1:0] rx_shift;

  ////////////////////////////////////////////////////////////////////////////
  // sender: start, nine bits lsb first, stop; high again afterwards
  initial begin
    dev_rx_line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (rst_n === 1'b1 && send === 1'b1) begin
        busy <= 1'b1;
        tx_frame = {~bad_stop, send_data, 1'b0};
        for (int i = 0; i < LINK_FRAME_BITS; i++) begin
          dev_rx_line <= tx_frame[i];
          repeat (LINK_BIT_CYC) @(posedge ref_clk);
        end
        dev_rx_line <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: samples mid bit on the falling edge, away from device updates
  initial begin
    got_valid = 1'b0;
    got_data = '0;
    got_err = 1'b0;
    forever begin
      @(negedge ref_clk);
      if (rst_n === 1'b1 && dev_tx_line === 1'b0) begin
        repeat (LINK_HALF_CYC) @(negedge ref_clk);
        for (int i = 0; i < LINK_FRAME_BITS; i++) begin
          rx_shift[i] = dev_tx_line;
          if (i < LINK_FRAME_BITS - 1) begin
            repeat (LINK_BIT_CYC) @(negedge ref_clk);
          end
        end
        @(posedge ref_clk);
        got_data <= rx_shift[LINK_DATA_BITS:1];
        got_err <= rx_shift[0] | ~rx_shift[LINK_FRAME_BITS-1];
        got_valid <= 1'b1;
        @(posedge ref_clk);
        got_valid <= 1'b0;
      end
    end
  end
endmodule

// File: dv/fcs_top_bench.sv
// self-checking bench for the floating controller support logic
`timescale 1ns/1ps
module fcs_top_bench;
  import fcs_pkg::*;
  localparam int unsigned MIN_CYC = 40;
  localparam int unsigned MAX_CYC = 60;
  localparam int unsigned TIME_CAP = 60000;
  logic ref_clk, rst_n, tx_valid, tx_ready, link_tx_line, link_rx_line;
  logic [LINK_DATA_BITS-1:0] tx_data, rx_data, send_data, got_data;
  logic rx_valid, rx_frame_err, line_sense_input, line_std60, line_meas_done;
  logic counter_carry_pulse, count_latch_req, count_latch_strobe;
  logic [CNT_LO_W-1:0] count_low;
  fcs_count_t count_value;
  fcs_supply_t supply_in;
  logic main_reset_n, power_loss_warning, wr_strobe_n_out;
  logic [PWM_W-1:0] pwm_duty;
  logic precharge_adjust_level, adc_start_req, adc_sel_freq;
  logic adc_input_sel, adc_start, send, bad_stop, busy, got_valid, got_err;
  logic [LINK_DATA_BITS-1:0] out_q[$];
  logic [LINK_DATA_BITS:0] in_q[$];
  logic [LINK_DATA_BITS:0] exp_i;
  logic [31:0] rnd;
  logic [15:0] hi_exp;
  logic hit;
  int err_count, checked, cycles, n;

  fcs_top #(.LINE_MIN_CYC(MIN_CYC), .LINE_MAX_CYC(MAX_CYC)) fcs_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .link_tx_line(link_tx_line),
    .link_rx_line(link_rx_line), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_err(rx_frame_err), .line_sense_input(line_sense_input),
    .line_std60(line_std60), .line_meas_done(line_meas_done),
    .counter_carry_pulse(counter_carry_pulse), .count_low(count_low),
    .count_latch_req(count_latch_req),
    .count_latch_strobe(count_latch_strobe), .count_value(count_value),
    .supply_in(supply_in), .main_reset_n(main_reset_n),
    .power_loss_warning(power_loss_warning),
    .wr_strobe_n_out(wr_strobe_n_out), .pwm_duty(pwm_duty),
    .precharge_adjust_level(precharge_adjust_level),
    .adc_start_req(adc_start_req), .adc_sel_freq(adc_sel_freq),
    .adc_input_sel(adc_input_sel), .adc_start(adc_start));

  fcs_iop_model fcs_iop_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .dev_tx_line(link_tx_line),
    .dev_rx_line(link_rx_line), .send(send), .send_data(send_data),
    .bad_stop(bad_stop), .busy(busy), .got_valid(got_valid),
    .got_data(got_data), .got_err(got_err));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task give_verdict;
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // request pulses are dropped after one cycle while waiting
  task automatic wait_sig(input int which, input int lim, output logic h);
    h = 1'b0;
    for (int k = 0; k < lim && !h; k++) begin
      @(negedge ref_clk);
      count_latch_req = 1'b0;
      adc_start_req = 1'b0;
      case (which)
        0: h = (line_meas_done === 1'b1);
        1: h = (count_latch_strobe === 1'b1);
        default: h = (adc_start === 1'b1);
      endcase
    end
  endtask

  task automatic send_in(input logic [LINK_DATA_BITS-1:0] d, input logic b);
    in_q.push_back({b, d});
    send = 1'b1;
    send_data = d;
    bad_stop = b;
    @(negedge ref_clk);
    send = 1'b0;
    @(negedge ref_clk);
    for (int k = 0; k < 2000 && busy === 1'b1; k++) @(negedge ref_clk);
  endtask

  task automatic line_case(input int p);
    repeat (3) begin
      line_sense_input = 1'b1;
      repeat (p / 2) @(negedge ref_clk);
      line_sense_input = 1'b0;
      repeat (p - p / 2) @(negedge ref_clk);
    end
    line_sense_input = 1'b1;
    wait_sig(0, 5, hit);
    chk(hit && line_std60 === (p >= MIN_CYC && p <= MAX_CYC),
        "line");
  endtask

  task automatic count_case(input int k);
    repeat (k) begin
      counter_carry_pulse = 1'b1;
      @(negedge ref_clk);
      counter_carry_pulse = 1'b0;
      @(negedge ref_clk);
    end
    hi_exp = hi_exp + k[15:0];
    rnd = lfsr(rnd);
    count_low = rnd[7:0];
    repeat (3) @(negedge ref_clk);
    count_latch_req = 1'b1;
    wait_sig(1, 4, hit);
    chk(hit && count_value === {hi_exp, count_low}, "count");
  endtask

  task automatic pwm_case(input logic [PWM_W-1:0] d);
    int h;
    pwm_duty = d;
    h = 0;
    repeat (2 * PWM_CYC + 4) @(negedge ref_clk);
    repeat (PWM_CYC) begin
      @(negedge ref_clk);
      if (precharge_adjust_level === 1'b1) h++;
    end
    chk(h == (int'(d) >= PWM_CYC ? PWM_CYC : int'(d)), "pwm duty");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // a hang is cut short here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TIME_CAP) begin
      chk(1'b0, "timeout");
      give_verdict;
    end
  end

  // oldest note is compared whenever a result shows up
  always @(negedge ref_clk) begin
    if (got_valid === 1'b1) begin
      chk(out_q.size() > 0, "stray frame");
      if (out_q.size() > 0) begin
        exp_i = {1'b0, out_q.pop_front()};
        chk(got_err === 1'b0 && got_data === exp_i[8:0], "out");
      end
    end
    if (rx_valid === 1'b1 || rx_frame_err === 1'b1) begin
      chk(in_q.size() > 0, "stray rx");
      exp_i = (in_q.size() > 0) ? in_q.pop_front() : '0;
      if (exp_i[LINK_DATA_BITS]) begin
        chk(rx_frame_err === 1'b1 && rx_valid !== 1'b1, "bad stop");
      end else begin
        chk(rx_valid === 1'b1 && rx_data === exp_i[8:0],
            "in word");
      end
    end
  end

  initial begin
    err_count = 0;
    checked = 0;
    cycles = 0;
    hi_exp = '0;
    rnd = 32'h24D57281;
    rst_n = 1'b0;
    {tx_valid, tx_data, line_sense_input, counter_carry_pulse} = '0;
    {count_low, count_latch_req, pwm_duty, adc_start_req} = '0;
    {adc_sel_freq, send, send_data, bad_stop} = '0;
    supply_in = fcs_supply_t'(3'h1);
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(link_tx_line === 1'b1, "tx idle");
    // fill the fifo back to back until it refuses
    n = 0;
    tx_valid = 1'b1;
    repeat (20) begin
      rnd = lfsr(rnd);
      tx_data = rnd[8:0];
      if (tx_ready === 1'b1) begin
        out_q.push_back(tx_data);
        n++;
      end
      @(negedge ref_clk);
    end
    tx_valid = 1'b0;
    chk(n == TX_FIFO_DEPTH + 1 && tx_ready === 1'b0, "fifo full");
    // inbound frames while the outbound queue drains
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      send_in(rnd[8:0], i == 2);
    end
    for (int k = 0; k < 30000 && out_q.size() > 0; k++) @(negedge ref_clk);
    chk(out_q.size() == 0 && in_q.size() == 0, "drained");
    line_case(39);
    line_case(40);
    line_case(60);
    line_case(61);
    line_case(50);
    repeat (MAX_CYC + 10) @(negedge ref_clk);
    chk(line_std60 === 1'b0, "line lost");
    count_case(1);
    count_case(0);
    count_case(5);
    for (int i = 0; i < 8; i++) begin
      supply_in = fcs_supply_t'(i[2:0]);
      repeat (2) @(negedge ref_clk);
      chk(main_reset_n === ~supply_in.regulated_low, "reset");
      chk(power_loss_warning === supply_in.unregulated_low, "warn");
      chk(wr_strobe_n_out === (supply_in.wr_strobe_n
          | supply_in.regulated_low), "wr gate");
    end
    supply_in = fcs_supply_t'(3'h1);
    pwm_case(11'h000);
    pwm_case(11'h43D);
    pwm_case(11'h7FF);
    for (int i = 0; i < 4; i++) begin
      adc_sel_freq = i[0];
      adc_start_req = 1'b1;
      wait_sig(2, 4, hit);
      chk(hit && adc_input_sel === adc_sel_freq, "adc sel");
      // one idle cycle so the request is not re-raised in the same step
      @(negedge ref_clk);
    end
    give_verdict;
  end
endmodule
